// ### logic/nsc_pkg.sv
// constants for the nand sequencer host controller
`default_nettype none
package nsc_pkg;
  // apb register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OP = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_RDATA = 8'h0C;
  // ctrl and op fields
  localparam int CTRL_WP_BIT = 0;
  localparam int OP_KIND_LSB = 8;
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_READ = 2'h2;
  localparam logic [1:0] KIND_WRITE = 2'h3;
  // status fields
  localparam int STAT_ENG_BUSY = 0;
  localparam int STAT_DEV_READY = 1;
  localparam int STAT_PWR_DONE = 2;
  localparam int STAT_SEQ_ERR = 3;
  localparam int STAT_REFUSED = 4;
  localparam int STAT_WP_REL = 5;
  // command bytes
  localparam logic [7:0] CMD_DUMMY_CONF = 8'h11;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_PL = 8'hF1;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_SETUP_80 = 8'h80;
  localparam logic [7:0] CMD_SETUP_81 = 8'h81;
  localparam logic [7:0] CMD_SETUP_85 = 8'h85;
  localparam logic [7:0] CMD_CHK_STAT = 8'h7B;
  // meaningful bits of a check-status byte: 0,1,2,6,7
  localparam logic [7:0] CHK_STATUS_MASK = 8'hC7;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int PWRUP_US = 100;
  localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
  localparam int WR_LOW_NS = 40;
  localparam int RD_LOW_NS = 120;
  localparam int HIGH_NS = 40;
  localparam int WR_LOW_CYC = (WR_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_LOW_CYC = (RD_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int HIGH_CYC = (HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 3;
  // engine states, gray along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_LOW = 2'b11,
    ST_HIGH = 2'b10
  } nsc_state_t;
endpackage
`default_nettype wire

// ### logic/nsc_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
module nsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  always_comb
  begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule
`default_nettype wire

// ### logic/nsc_host.sv
// apb-controlled host sequencer driving a nand flash pin interface
// Notes on behaviour
// - host masks undefined status bits 3 to 5 when evaluating status.
// - id mode is command 90h followed by one address cycle 00h.
// - host waits at least 100 us after power-up before any command.
// - host holds write protect low during power-up and power-down.
// - host never changes write protect while the device is busy; the gate uses the synchronised ready, which falls four cycles after rb_n_in.
// - after 11h only 70h, F1h or FFh may precede 81h; the guard also accepts 80h or 85h in between.
// - after 11h only 70h, F1h or FFh may precede 80h; the guard also accepts 81h or 85h in between.
// - read cycles after 7Bh return the check-status byte.
`default_nettype none
module nsc_host #(
  parameter int PWRUP_CYCLES = nsc_pkg::PWRUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  output logic cle,
  output logic ale,
  output logic ce_n,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  input wire logic rb_n_in
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] pins_s;
  logic dev_ready;
  logic [7:0] io_s;

  nsc_sync #(.WIDTH(9), .INIT(9'h100)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({rb_n_in, io_in}),
    .dout(pins_s)
  );
  assign dev_ready = pins_s[8];
  assign io_s = pins_s[7:0];

  // ----------------------------------------------------------------
  // registers and engine state
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] prdata_q, prdata_d;
  logic ctrl_wp_q, ctrl_wp_d;
  logic wp_n_q, wp_n_d;
  logic [31:0] pwr_cnt_q, pwr_cnt_d;
  logic pwr_done_q, pwr_done_d;
  logic seq_err_q, seq_err_d;
  logic refused_q, refused_d;
  logic dummy_q, dummy_d;
  nsc_pkg::nsc_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [1:0] kind_q, kind_d;
  logic [7:0] byte_q, byte_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] last_cmd_q, last_cmd_d;
  logic [7:0] io_out_q, io_out_d;
  logic io_oe_q, io_oe_d;
  logic cle_q, cle_d;
  logic ale_q, ale_d;
  logic ce_n_q, ce_n_d;
  logic we_n_q, we_n_d;
  logic re_n_q, re_n_d;
  logic [31:0] stat_w;
  logic [1:0] op_kind;
  logic [7:0] op_byte;
  logic [7:0] low_len;
  logic start, refuse, seq_bad, allowed, status_mode;

  // ----------------------------------------------------------------
  // apb decode, one wait state so read data leave a flop
  // ----------------------------------------------------------------
  logic acc, done, wr, mapped;
  logic wr_ctrl, wr_op, wr_stat;
  assign acc = psel && penable;
  assign done = acc && ack_q;
  assign wr = done && pwrite;
  assign mapped = (paddr == nsc_pkg::ADDR_CTRL) ||
                  (paddr == nsc_pkg::ADDR_OP) ||
                  (paddr == nsc_pkg::ADDR_STAT) ||
                  (paddr == nsc_pkg::ADDR_RDATA);
  assign wr_ctrl = wr && (paddr == nsc_pkg::ADDR_CTRL);
  assign wr_op = wr && (paddr == nsc_pkg::ADDR_OP);
  assign wr_stat = wr && (paddr == nsc_pkg::ADDR_STAT);
  assign pready = done;
  assign pslverr = done && !mapped;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // operation decode and ordering guard
  // ----------------------------------------------------------------
  assign op_kind = pwdata[nsc_pkg::OP_KIND_LSB +: 2];
  assign op_byte = pwdata[7:0];
  assign allowed = (op_byte == nsc_pkg::CMD_STATUS) ||
                   (op_byte == nsc_pkg::CMD_STATUS_PL) ||
                   (op_byte == nsc_pkg::CMD_RESET) ||
                   (op_byte == nsc_pkg::CMD_SETUP_80) ||
                   (op_byte == nsc_pkg::CMD_SETUP_81) ||
                   (op_byte == nsc_pkg::CMD_SETUP_85);
  // among commands, only status, reset or a setup may follow a dummy confirm; address and data ops are not checked
  assign seq_bad = dummy_q && (op_kind == nsc_pkg::KIND_CMD) &&
                   !allowed;
  // nothing leaves before the power-up wait ends
  assign refuse = wr_op && ((state_q != nsc_pkg::ST_IDLE) ||
                  !pwr_done_q || seq_bad);
  assign start = wr_op && !refuse;
  assign status_mode = (last_cmd_q == nsc_pkg::CMD_STATUS) ||
                       (last_cmd_q == nsc_pkg::CMD_STATUS_PL) ||
                       (last_cmd_q == nsc_pkg::CMD_CHK_STAT);
  assign low_len = (kind_q == nsc_pkg::KIND_READ) ?
                   8'(nsc_pkg::RD_LOW_CYC) : 8'(nsc_pkg::WR_LOW_CYC);

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_comb
  begin
    stat_w = 32'h0;
    stat_w[nsc_pkg::STAT_ENG_BUSY] = (state_q != nsc_pkg::ST_IDLE);
    stat_w[nsc_pkg::STAT_DEV_READY] = dev_ready;
    stat_w[nsc_pkg::STAT_PWR_DONE] = pwr_done_q;
    stat_w[nsc_pkg::STAT_SEQ_ERR] = seq_err_q;
    stat_w[nsc_pkg::STAT_REFUSED] = refused_q;
    stat_w[nsc_pkg::STAT_WP_REL] = wp_n_q;
  end

  // ----------------------------------------------------------------
  // bus group
  // ----------------------------------------------------------------
  always_comb
  begin
    ack_d = acc && !ack_q;
    prdata_d = prdata_q;
    if (acc && !ack_q)
    begin
      case (paddr)
        nsc_pkg::ADDR_CTRL: prdata_d = {31'h0, ctrl_wp_q};
        nsc_pkg::ADDR_OP: prdata_d = {22'h0, kind_q, byte_q};
        nsc_pkg::ADDR_STAT: prdata_d = stat_w;
        nsc_pkg::ADDR_RDATA: prdata_d = {24'h0, rdata_q};
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      ack_q <= ack_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // control group
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_wp_d = ctrl_wp_q;
    wp_n_d = wp_n_q;
    pwr_cnt_d = pwr_cnt_q;
    seq_err_d = seq_err_q;
    refused_d = refused_q;
    if (wr_ctrl)
    begin
      ctrl_wp_d = pwdata[nsc_pkg::CTRL_WP_BIT];
    end
    if (pwr_cnt_q != 32'(PWRUP_CYCLES))
    begin
      pwr_cnt_d = pwr_cnt_q + 32'h1;
    end
    pwr_done_d = (pwr_cnt_d == 32'(PWRUP_CYCLES));
    // protect only moves while the device and engine are idle
    if (pwr_done_q && dev_ready && (state_q == nsc_pkg::ST_IDLE) &&
        !start)
    begin
      wp_n_d = ctrl_wp_q;
    end
    // write one to clear; a new event in the same cycle wins
    if (wr_stat && pwdata[nsc_pkg::STAT_SEQ_ERR])
    begin
      seq_err_d = 1'b0;
    end
    if (wr_stat && pwdata[nsc_pkg::STAT_REFUSED])
    begin
      refused_d = 1'b0;
    end
    if (wr_op && seq_bad)
    begin
      seq_err_d = 1'b1;
    end
    if (refuse)
    begin
      refused_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_wp_q <= 1'b0;
      wp_n_q <= 1'b0;
      pwr_cnt_q <= 32'h0;
      pwr_done_q <= 1'b0;
      seq_err_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      ctrl_wp_q <= ctrl_wp_d;
      wp_n_q <= wp_n_d;
      pwr_cnt_q <= pwr_cnt_d;
      pwr_done_q <= pwr_done_d;
      seq_err_q <= seq_err_d;
      refused_q <= refused_d;
    end
  end

  // ----------------------------------------------------------------
  // engine group
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    byte_d = byte_q;
    rdata_d = rdata_q;
    last_cmd_d = last_cmd_q;
    dummy_d = dummy_q;
    case (state_q)
      nsc_pkg::ST_IDLE:
      begin
        if (start)
        begin
          kind_d = op_kind;
          byte_d = op_byte;
          cnt_d = 8'h00;
          state_d = nsc_pkg::ST_SETUP;
          if (op_kind == nsc_pkg::KIND_CMD)
          begin
            last_cmd_d = op_byte;
            if (op_byte == nsc_pkg::CMD_DUMMY_CONF)
            begin
              dummy_d = 1'b1;
            end
            else if ((op_byte != nsc_pkg::CMD_STATUS) &&
                     (op_byte != nsc_pkg::CMD_STATUS_PL))
            begin
              dummy_d = 1'b0;
            end
          end
        end
      end
      nsc_pkg::ST_SETUP:
      begin
        state_d = nsc_pkg::ST_LOW;
      end
      nsc_pkg::ST_LOW:
      begin
        if (cnt_q == low_len - 8'h01)
        begin
          cnt_d = 8'h00;
          state_d = nsc_pkg::ST_HIGH;
          if (kind_q == nsc_pkg::KIND_READ)
          begin
            // undefined status bits are masked in status modes
            rdata_d = status_mode ? (io_s & nsc_pkg::CHK_STATUS_MASK) :
                      io_s;
          end
        end
        else
        begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      nsc_pkg::ST_HIGH:
      begin
        if (cnt_q == 8'(nsc_pkg::HIGH_CYC) - 8'h01)
        begin
          cnt_d = 8'h00;
          state_d = nsc_pkg::ST_IDLE;
        end
        else
        begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      default:
      begin
        state_d = nsc_pkg::ST_IDLE;
      end
    endcase
    // pin levels follow the next state
    ce_n_d = (state_d == nsc_pkg::ST_IDLE);
    cle_d = (state_d != nsc_pkg::ST_IDLE) &&
            (kind_d == nsc_pkg::KIND_CMD);
    ale_d = (state_d != nsc_pkg::ST_IDLE) &&
            (kind_d == nsc_pkg::KIND_ADDR);
    io_oe_d = (state_d != nsc_pkg::ST_IDLE) &&
              (kind_d != nsc_pkg::KIND_READ);
    io_out_d = byte_d;
    we_n_d = !((state_d == nsc_pkg::ST_LOW) &&
               (kind_d != nsc_pkg::KIND_READ));
    re_n_d = !((state_d == nsc_pkg::ST_LOW) &&
               (kind_d == nsc_pkg::KIND_READ));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= nsc_pkg::ST_IDLE;
      cnt_q <= 8'h00;
      kind_q <= 2'h0;
      byte_q <= 8'h00;
      rdata_q <= 8'h00;
      last_cmd_q <= 8'h00;
      dummy_q <= 1'b0;
      io_out_q <= 8'h00;
      io_oe_q <= 1'b0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      byte_q <= byte_d;
      rdata_q <= rdata_d;
      last_cmd_q <= last_cmd_d;
      dummy_q <= dummy_d;
      io_out_q <= io_out_d;
      io_oe_q <= io_oe_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign cle = cle_q;
  assign ale = ale_q;
  assign ce_n = ce_n_q;
  assign we_n = we_n_q;
  assign re_n = re_n_q;
  assign wp_n = wp_n_q;
endmodule
`default_nettype wire

// ### verification/nsc_properties.sv
// port checker for the nand host controller
`default_nettype none
module nsc_properties #(
  parameter int PWRUP_CYCLES = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic io_oe,
  input wire logic wp_n,
  input wire logic rb_n_in
);
  int cnt_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_q <= 0;
    else if (cnt_q < PWRUP_CYCLES) cnt_q <= cnt_q + 1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pwrup_quiet: assert property (cnt_q < PWRUP_CYCLES |-> we_n)
    else $error("write strobe inside power-up wait");
  chk_pwrup_wp: assert property (cnt_q < PWRUP_CYCLES |-> !wp_n)
    else $error("write protect released during power-up");
  sequence busy_two;
    !rb_n_in ##1 !rb_n_in;
  endsequence
  sequence write_framed;
    !ce_n && (cle || ale || io_oe);
  endsequence
  chk_wp_busy: assert property (busy_two |-> $stable(wp_n))
    else $error("write protect changed while busy");
  chk_cle_ale: assert property (!(cle && ale))
    else $error("command and address latch both high");
  chk_strobe_excl: assert property (!we_n |-> re_n)
    else $error("write and read strobes low together");
  chk_oe_read: assert property (!re_n |-> !io_oe)
    else $error("data driven during a read strobe");
  chk_we_frame: assert property ($fell(we_n) |-> write_framed)
    else $error("write strobe outside a selected cycle");
endmodule
bind nsc_host nsc_properties #(.PWRUP_CYCLES(PWRUP_CYCLES)) chk_u (
  .pclk(pclk), .presetn(presetn), .we_n(we_n), .re_n(re_n),
  .ce_n(ce_n), .cle(cle), .ale(ale), .io_oe(io_oe), .wp_n(wp_n),
  .rb_n_in(rb_n_in));
`default_nettype wire

// ### verification/nsc_flash_model.sv
// behavioural nand device on the far side
`default_nettype none
module nsc_flash_model #(
  parameter logic [7:0] ID_BASE = 8'h30 // arbitrary id value
) (
  input wire logic [7:0] io_out,
  input wire logic cle,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  output logic [7:0] io_in,
  output logic rb_dn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cmd_q = 8'h00;
  logic [7:0] q = 8'h00;
  int n = 0;
  initial rb_dn = 1'b0;
  always @(posedge we_n)
    if (!ce_n && cle)
    begin
      cmd_q = io_out;
      n = 0;
      if (io_out == 8'hFF)
      begin
        rb_dn = 1'b1;
        rb_dn <= #1000 1'b0;
      end
    end
  always @(negedge re_n)
    if (!ce_n)
      q = cmd_q == 8'h90 ? ID_BASE + n : {wp_n, !rb_dn, 6'h38};
  always @(posedge re_n) n = n + 1;
  assign io_in = (!ce_n && !re_n) ? q : ~q;
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the nand host controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, io_out, io_in;
  logic [31:0] pwdata = 0, prdata, v;
  logic io_oe, cle, ale, ce_n, we_n, re_n, wp_n, pready, pslverr, rb_dn;
  logic se;
  int errors = 0, checked = 0;
  always #10 pclk = ~pclk;
  nsc_host #(.PWRUP_CYCLES(40)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .cle(cle), .ale(ale),
    .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .rb_n_in(!rb_dn));
  nsc_flash_model #(.ID_BASE(8'h30)) dev_u (.io_out(io_out), .cle(cle),
    .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_in(io_in),
    .rb_dn(rb_dn));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    v = prdata;
    se = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic op(input logic [1:0] k, input logic [7:0] b);
    apb(1, nsc_pkg::ADDR_OP, {22'h0, k, b});
    do apb(0, nsc_pkg::ADDR_STAT, 0); while (v[nsc_pkg::STAT_ENG_BUSY] !== 0);
  endtask
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #200000;
    errors++;
    results;
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(1, nsc_pkg::ADDR_OP, {22'h0, nsc_pkg::KIND_CMD, 8'h90});
    apb(0, nsc_pkg::ADDR_STAT, 0);
    chk("early refuse", 8'h01, {6'h0, v[nsc_pkg::STAT_PWR_DONE],
      v[nsc_pkg::STAT_REFUSED]});
    apb(1, nsc_pkg::ADDR_STAT, 32'h1 << nsc_pkg::STAT_REFUSED);
    do apb(0, nsc_pkg::ADDR_STAT, 0); while (v[nsc_pkg::STAT_PWR_DONE] !== 1);
    apb(0, 8'hF0, 0);
    chk("unmapped error", 8'h01, {7'h0, se});
    apb(1, nsc_pkg::ADDR_CTRL, 1);
    apb(0, nsc_pkg::ADDR_STAT, 0);
    chk("wp released", 8'h01, {7'h0, v[nsc_pkg::STAT_WP_REL]});
    op(nsc_pkg::KIND_CMD, 8'h90);
    op(nsc_pkg::KIND_ADDR, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      op(nsc_pkg::KIND_READ, 0);
      apb(0, nsc_pkg::ADDR_RDATA, 0);
      chk("id byte", 8'h30 + i, v[7:0]);
    end
    op(nsc_pkg::KIND_CMD, 8'h11);
    op(nsc_pkg::KIND_CMD, 8'h90);
    apb(0, nsc_pkg::ADDR_STAT, 0);
    chk("order refuse", 8'h03, {6'h0, v[nsc_pkg::STAT_REFUSED],
      v[nsc_pkg::STAT_SEQ_ERR]});
    apb(1, nsc_pkg::ADDR_STAT, 32'h18);
    op(nsc_pkg::KIND_CMD, 8'h80);
    op(nsc_pkg::KIND_WRITE, 8'h5A);
    apb(0, nsc_pkg::ADDR_STAT, 0);
    chk("order pass", 8'h00, {6'h0, v[nsc_pkg::STAT_REFUSED],
      v[nsc_pkg::STAT_SEQ_ERR]});
    op(nsc_pkg::KIND_CMD, 8'hFF);
    op(nsc_pkg::KIND_CMD, 8'hFF);
    do apb(0, nsc_pkg::ADDR_STAT, 0); while (v[nsc_pkg::STAT_DEV_READY] !== 1);
    op(nsc_pkg::KIND_CMD, 8'h7B);
    op(nsc_pkg::KIND_READ, 0);
    apb(0, nsc_pkg::ADDR_RDATA, 0);
    chk("check status", 8'hC0, v[7:0]);
    results;
  end
endmodule
`default_nettype wire
